//--- inc/charger_regs_pkg.sv
package charger_regs_pkg;

  // ****************************************
  // Serial link addressing
  // ****************************************
  localparam logic [6:0] SLAVE_ADDR      = 7'h6b;
  localparam logic [7:0] ADDR_INPUT_SRC  = 8'h00;
  localparam logic [7:0] ADDR_POWER_ON   = 8'h01;
  localparam logic [7:0] ADDR_CHARGE_CUR = 8'h02;
  localparam logic [7:0] ADDR_LAST_RW    = 8'h07;
  localparam logic [7:0] ADDR_STATUS     = 8'h08;
  localparam logic [7:0] ADDR_FAULT      = 8'h09;
  localparam logic [7:0] ADDR_LAST       = 8'h0a;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  localparam logic [3:0] LAST_TX_BIT     = 4'h7;

  // ****************************************
  // Reset values of the writable bytes
  // ****************************************
  localparam logic [7:0] RST_INPUT_SRC   = 8'h58;
  localparam logic [7:0] RST_POWER_ON    = 8'h3b;
  localparam logic [7:0] RST_CHARGE_CUR  = 8'h20;
  localparam logic [7:0] RST_PRECHG_TERM = 8'h11;
  localparam logic [7:0] RST_CHARGE_VOLT = 8'hb2;
  localparam logic [7:0] RST_AUX5        = 8'h00;
  localparam logic [7:0] RST_AUX6        = 8'h00;
  localparam logic [7:0] RST_AUX7        = 8'h00;
  localparam logic [63:0] RST_IMAGE = {RST_AUX7, RST_AUX6, RST_AUX5, RST_CHARGE_VOLT,
                                       RST_PRECHG_TERM, RST_CHARGE_CUR, RST_POWER_ON,
                                       RST_INPUT_SRC};

  // ****************************************
  // Field positions
  // ****************************************
  localparam int HIZ_BIT    = 7;
  localparam int VFLOOR_HI  = 6;
  localparam int VFLOOR_LO  = 3;
  localparam int ICAP_HI    = 2;
  localparam int ICAP_LO    = 0;
  localparam int REGRST_BIT = 7;
  localparam int WDT_BIT    = 6;
  localparam int BOOST_BIT  = 5;
  localparam int CHG_BIT    = 4;
  localparam int SYSMIN_HI  = 3;
  localparam int SYSMIN_LO  = 1;
  localparam int FAST_CHARGE_CURRENT_HI    = 7;
  localparam int FAST_CHARGE_CURRENT_LO    = 2;
  localparam int BCOLD_BIT  = 1;
  localparam int REDUCE_BIT = 0;

  // ****************************************
  // Source type and its current cap default
  // ****************************************
  typedef enum logic [1:0] {
    SRC_HOST_PORT  = 2'h0,
    SRC_DEDICATED  = 2'h1,
    SRC_DIVIDER_12 = 2'h2,
    SRC_DIVIDER_3  = 2'h3
  } src_type_t;
  localparam logic [2:0] ICAP_HOST_PORT  = 3'h2;
  localparam logic [2:0] ICAP_DEDICATED  = 3'h5;
  localparam logic [2:0] ICAP_DIVIDER_12 = 3'h6;
  localparam logic [2:0] ICAP_DIVIDER_3  = 3'h4;

  // ****************************************
  // Link state machine
  // ****************************************
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_MACK = 5'h10
  } link_state_t;

endpackage

//--- rtl/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_sys_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  // Two stages; idle bus level is high, so reset to ones
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_reg <= '1;
      q_o      <= '1;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule

//--- rtl/reg_store.sv
`timescale 1ns/1ns
module reg_store (
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  input  wire logic        def_load_i,
  input  wire logic [2:0]  cap_default_i,
  input  wire logic        wr_en_i,
  input  wire logic [2:0]  addr_i,
  input  wire logic [7:0]  wr_data_i,
  output logic      [7:0]  rd_data_o,
  output logic      [63:0] regs_o
);
  import charger_regs_pkg::*;

  logic [7:0] mem_reg [0:7];
  logic [7:0] wr_word;

  // Command bits of the power byte never stick
  assign wr_word = (addr_i == ADDR_POWER_ON[2:0]) ?
                   {2'h0, wr_data_i[5:0]} : wr_data_i;

  // Default load beats a write in the same cycle
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < 8; i++) begin
        mem_reg[i] <= RST_IMAGE[8*i +: 8];
      end
    end else if (def_load_i) begin
      for (int i = 0; i < 8; i++) begin
        mem_reg[i] <= RST_IMAGE[8*i +: 8];
      end
      mem_reg[0][ICAP_HI:ICAP_LO] <= cap_default_i;
    end else if (wr_en_i) begin
      mem_reg[addr_i] <= wr_word;
    end
  end

  // Registered read port
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= mem_reg[addr_i];
    end
  end

  // Flat view of every byte for the field outputs
  for (genvar g = 0; g < 8; g++) begin : g_flat
    assign regs_o[8*g +: 8] = mem_reg[g];
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  reg_reset_a: assert property (def_load_i |=> (mem_reg[1] == RST_POWER_ON &&
                                mem_reg[2] == RST_CHARGE_CUR))
    else $error("default load did not restore the configuration bytes");
  self_clear_a: assert property (wr_en_i && !def_load_i && addr_i == 3'h1
                                 |=> mem_reg[1][7:6] == 2'h0)
    else $error("command bits of the power byte stuck after a write");
endmodule

//--- rtl/charger_i2c_register_bank.sv
`timescale 1ns/1ns
// Functional notes
// - Fault byte latches every fault until a read of it completes.
// - After that read, the fault byte shows faults present now and any latched after it was captured.
// - Fault byte takes single-byte access only; no auto-increment there.
// - Answer at address 6bh; bytes 00 to 07 read back what was written, except power byte bits 7:6.
// - Bytes 08 to 0a are read only; writes leave them unchanged.
// - Input source byte resets to 58h; bit 7 is high-impedance enable.
// - Bits 6:3 are the input voltage floor code, default 1011.
// - Bits 2:0 select the input current cap, 100 mA to 3 A.
// - Current cap default follows the detected source type.
// - Power byte resets to 3bh; bit 0 reserved, resets to one.
// - Bit 7 write restores all defaults but keeps host-controlled operation.
// - Bit 6 write restarts the watchdog; writing zero does nothing.
// - Boost enable bit 5 overrides charge enable; no charging while set.
// - Bit 4 enables charging, reset value one.
// - Bits 3:1 are the minimum system voltage code, default 101.
// - Charge current byte resets to 20h; all its fields are writable.
// - Any host write moves the device into host-controlled operation.
// - Burst access auto-increments across addresses 00 to 08.
// - Undefined register address gets a not-acknowledge and back to idle.
module charger_i2c_register_bank #(
  parameter logic [7:0] VENDOR_INFO = 8'h5a  // Arbitrary value
) (
  input  wire logic                        clk_sys_i,
  input  wire logic                        arst_n_i,
  input  wire logic                        scl_i,
  input  wire logic                        sda_i,
  output logic                             sda_o,
  output logic                             sda_oe_o,
  input  wire logic [7:0]                  fault_i,
  input  wire logic [7:0]                  status_i,
  input  wire charger_regs_pkg::src_type_t src_type_i,
  input  wire logic                        watchdog_expired_i,
  output logic                             input_high_impedance_enable_o,
  output logic      [3:0]                  input_voltage_floor_o,
  output logic      [2:0]                  input_current_cap_o,
  output logic                             boost_output_enable_o,
  output logic                             charge_enable_o,
  output logic      [2:0]                  min_system_voltage_o,
  output logic      [5:0]                  fast_charge_current_o,
  output logic                             boost_cold_select_o,
  output logic                             reduced_current_force_o,
  output logic                             host_mode_o,
  output logic                             watchdog_restart_o
);
  import charger_regs_pkg::*;

  // ****************************************
  // Pin sampling and bus events
  // ****************************************
  logic [1:0]  pins_s;
  logic        scl_s;
  logic        sda_s;
  logic        scl_d_reg;
  logic        sda_d_reg;
  wire  logic  scl_rise;
  wire  logic  scl_fall;
  wire  logic  start_det;
  wire  logic  stop_det;

  pin_sync #(
    .W(2)
  ) u_pin_sync (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .d_i       ({scl_i, sda_i}),
    .q_o       (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Edges come from the synchronised copies only
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ****************************************
  // Link state
  // ****************************************
  link_state_t state_reg, state_next;
  logic [3:0]  bit_cnt_reg, bit_cnt_next;
  logic [7:0]  shift_reg, shift_next;
  logic [7:0]  ptr_reg, ptr_next;
  logic        got_dev_reg, got_dev_next;
  logic        got_reg_reg, got_reg_next;
  logic        read_mode_reg, read_mode_next;
  logic        m_ack_reg, m_ack_next;
  logic        sda_oe_reg, sda_oe_next;
  logic [7:0]  fault_latch_reg, fault_latch_next;
  logic [7:0]  fault_snap_reg, fault_snap_next;
  logic        host_mode_reg;
  logic        wdt_pulse_reg;
  logic        charge_en_reg;
  logic        init_done_reg;

  // ****************************************
  // Byte decisions
  // ****************************************
  logic [63:0] regs_w;
  logic [7:0]  store_rd;
  wire  logic [7:0] src_byte;
  wire  logic [7:0] pwr_byte;
  wire  logic [7:0] chg_byte;
  wire  logic       byte_done;
  wire  logic       addr_match;
  wire  logic       dev_ack;
  wire  logic       reg_ack;
  wire  logic       data_phase;
  wire  logic       rx_ack;
  wire  logic       data_wr;
  wire  logic       pwr_wr;
  wire  logic       soft_reset;
  wire  logic       wdt_kick;
  wire  logic       def_load;
  wire  logic       ptr_adv;
  wire  logic       tx_load;
  wire  logic       read_done;
  wire  logic [7:0] fault_view;
  wire  logic [7:0] tx_src;
  wire  logic [2:0] cap_default;

  assign byte_done  = (state_reg == ST_RX) && scl_fall && (bit_cnt_reg == BITS_PER_BYTE);
  assign addr_match = (shift_reg[7:1] == SLAVE_ADDR);
  assign dev_ack    = !got_dev_reg && addr_match;
  assign reg_ack    = got_dev_reg && !got_reg_reg && (shift_reg <= ADDR_LAST);
  assign data_phase = got_dev_reg && got_reg_reg;
  assign rx_ack     = dev_ack || reg_ack || data_phase;
  assign data_wr    = byte_done && data_phase;
  assign pwr_wr     = data_wr && (ptr_reg == ADDR_POWER_ON);
  assign soft_reset = pwr_wr && shift_reg[REGRST_BIT];
  assign wdt_kick   = pwr_wr && shift_reg[WDT_BIT];
  assign def_load   = soft_reset || !init_done_reg;
  // Burst stops at 08; the fault byte never advances
  assign ptr_adv    = (ptr_reg < ADDR_STATUS);
  assign tx_load    = scl_fall && (((state_reg == ST_ACK) && read_mode_reg) ||
                                   ((state_reg == ST_MACK) && m_ack_reg));
  assign read_done  = (state_reg == ST_MACK) && scl_rise && (ptr_reg == ADDR_FAULT);
  assign fault_view = fault_latch_reg | fault_i;

  // Read source: stored bytes, then live status, faults and info
  assign tx_src = (ptr_reg <= ADDR_LAST_RW) ? store_rd :
                  (ptr_reg == ADDR_STATUS)  ? status_i :
                  (ptr_reg == ADDR_FAULT)   ? fault_view : VENDOR_INFO;

  // Current cap default picked by the detected source
  assign cap_default = (src_type_i == SRC_HOST_PORT)  ? ICAP_HOST_PORT :
                       (src_type_i == SRC_DEDICATED)  ? ICAP_DEDICATED :
                       (src_type_i == SRC_DIVIDER_12) ? ICAP_DIVIDER_12 :
                                                        ICAP_DIVIDER_3;

  assign src_byte = regs_w[7:0];
  assign pwr_byte = regs_w[15:8];
  assign chg_byte = regs_w[23:16];

  // ****************************************
  // Writable byte store
  // ****************************************
  reg_store u_reg_store (
    .clk_sys_i     (clk_sys_i),
    .arst_n_i      (arst_n_i),
    .def_load_i    (def_load),
    .cap_default_i (cap_default),
    .wr_en_i       (data_wr && (ptr_reg <= ADDR_LAST_RW)),
    .addr_i        (ptr_reg[2:0]),
    .wr_data_i     (shift_reg),
    .rd_data_o     (store_rd),
    .regs_o        (regs_w)
  );

  // ****************************************
  // Link sequencing
  // ****************************************
  // Start and stop override any phase; no clock stretching is used
  always_comb begin
    state_next       = state_reg;
    bit_cnt_next     = bit_cnt_reg;
    shift_next       = shift_reg;
    ptr_next         = ptr_reg;
    got_dev_next     = got_dev_reg;
    got_reg_next     = got_reg_reg;
    read_mode_next   = read_mode_reg;
    m_ack_next       = m_ack_reg;
    sda_oe_next      = sda_oe_reg;
    fault_snap_next  = fault_snap_reg;
    if (start_det) begin
      state_next   = ST_RX;
      bit_cnt_next = 4'h0;
      got_dev_next = 1'b0;
      got_reg_next = 1'b0;
      sda_oe_next  = 1'b0;
    end else if (stop_det) begin
      state_next  = ST_IDLE;
      sda_oe_next = 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          sda_oe_next = 1'b0;
        end
        ST_RX: begin
          if (scl_rise) begin
            shift_next   = {shift_reg[6:0], sda_s};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            if (!got_dev_reg) begin
              got_dev_next   = dev_ack;
              read_mode_next = shift_reg[0];
            end else if (!got_reg_reg) begin
              got_reg_next = reg_ack;
              ptr_next     = shift_reg;
            end else if (ptr_adv) begin
              ptr_next = ptr_reg + 8'h01;
            end
            sda_oe_next = rx_ack;
            state_next  = rx_ack ? ST_ACK : ST_IDLE;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_next = 4'h0;
            sda_oe_next  = 1'b0;
            state_next   = ST_RX;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == LAST_TX_BIT) begin
              sda_oe_next = 1'b0;
              state_next  = ST_MACK;
            end else begin
              sda_oe_next  = ~shift_reg[6];
              shift_next   = {shift_reg[6:0], 1'b0};
              bit_cnt_next = bit_cnt_reg + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            m_ack_next = ~sda_s;
            if (!sda_s && ptr_adv) begin
              ptr_next = ptr_reg + 8'h01;
            end
          end else if (scl_fall && !m_ack_reg) begin
            state_next = ST_IDLE;
          end
        end
      endcase
      // Load a byte for transmit, drive its first bit at once
      if (tx_load) begin
        shift_next   = tx_src;
        sda_oe_next  = ~tx_src[7];
        bit_cnt_next = 4'h0;
        state_next   = ST_TX;
        if (ptr_reg == ADDR_FAULT) begin
          fault_snap_next = fault_view;
        end
      end
    end
  end

  // Faults keep latching; a finished read clears only what it reported
  assign fault_latch_next = read_done ? (fault_i | (fault_latch_reg & ~fault_snap_reg)) :
                                        (fault_latch_reg | fault_i);

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg     <= ST_IDLE;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 8'h00;
      ptr_reg       <= 8'h00;
      got_dev_reg   <= 1'b0;
      got_reg_reg   <= 1'b0;
      read_mode_reg <= 1'b0;
      m_ack_reg     <= 1'b0;
      sda_oe_reg    <= 1'b0;
    end else begin
      state_reg     <= state_next;
      bit_cnt_reg   <= bit_cnt_next;
      shift_reg     <= shift_next;
      ptr_reg       <= ptr_next;
      got_dev_reg   <= got_dev_next;
      got_reg_reg   <= got_reg_next;
      read_mode_reg <= read_mode_next;
      m_ack_reg     <= m_ack_next;
      sda_oe_reg    <= sda_oe_next;
    end
  end

  // ****************************************
  // Faults, mode and control outputs
  // ****************************************
  // Host mode survives a register reset; only watchdog expiry ends it
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fault_latch_reg <= 8'h00;
      fault_snap_reg  <= 8'h00;
      host_mode_reg   <= 1'b0;
      wdt_pulse_reg   <= 1'b0;
      charge_en_reg   <= 1'b0;
      init_done_reg   <= 1'b0;
    end else begin
      fault_latch_reg <= fault_latch_next;
      fault_snap_reg  <= fault_snap_next;
      host_mode_reg   <= data_wr || (host_mode_reg && !watchdog_expired_i);
      wdt_pulse_reg   <= wdt_kick;
      charge_en_reg   <= pwr_byte[CHG_BIT] && !pwr_byte[BOOST_BIT];
      init_done_reg   <= 1'b1;
    end
  end

  // Open drain: the data level is always low, the enable does the work
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  assign sda_oe_o                      = sda_oe_reg;
  assign host_mode_o                   = host_mode_reg;
  assign watchdog_restart_o            = wdt_pulse_reg;
  assign charge_enable_o               = charge_en_reg;
  assign input_high_impedance_enable_o = src_byte[HIZ_BIT];
  assign input_voltage_floor_o         = src_byte[VFLOOR_HI:VFLOOR_LO];
  assign input_current_cap_o           = src_byte[ICAP_HI:ICAP_LO];
  assign boost_output_enable_o         = pwr_byte[BOOST_BIT];
  assign min_system_voltage_o          = pwr_byte[SYSMIN_HI:SYSMIN_LO];
  assign fast_charge_current_o         = chg_byte[FAST_CHARGE_CURRENT_HI:FAST_CHARGE_CURRENT_LO];
  assign boost_cold_select_o           = chg_byte[BCOLD_BIT];
  assign reduced_current_force_o       = chg_byte[REDUCE_BIT];

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  sequence ack_phase_s;
    (state_reg == ST_ACK) && sda_oe_reg;
  endsequence

  sequence kick_pulse_s;
    watchdog_restart_o ##1 !watchdog_restart_o;
  endsequence

  addr_ack_a: assert property (byte_done && !got_dev_reg && addr_match |=> ack_phase_s)
    else $error("own slave address not acknowledged");
  undef_nack_a: assert property (byte_done && got_dev_reg && !got_reg_reg
                                 && shift_reg > ADDR_LAST |=> state_reg == ST_IDLE && !sda_oe_reg)
    else $error("undefined register address was acknowledged");
  fault_hold_a: assert property (!read_done |=>
                                 (fault_latch_reg & $past(fault_latch_reg)) == $past(fault_latch_reg))
    else $error("latched fault lost without a read");
  fault_recover_a: assert property (read_done |=>
                                    (fault_latch_reg & $past(fault_snap_reg) & ~$past(fault_i)) == 8'h00)
    else $error("recovered fault still reported after read");
  snap_first_a: assert property (tx_load && ptr_reg == ADDR_FAULT |=>
                                 fault_snap_reg == $past(fault_view) ##1 state_reg == ST_TX)
    else $error("fault byte not captured before clearing");
  fault_no_incr_a: assert property ((state_reg == ST_MACK) && scl_rise
                                    && ptr_reg == ADDR_FAULT |=> ptr_reg == ADDR_FAULT)
    else $error("address advanced past the fault byte");
  burst_incr_a: assert property (data_wr && ptr_reg < ADDR_STATUS
                                 |=> ptr_reg == $past(ptr_reg) + 8'h01)
    else $error("burst write did not advance the address");
  ro_write_a: assert property (data_wr && ptr_reg > ADDR_LAST_RW |=> $stable(regs_w))
    else $error("write to a read-only byte changed the store");
  host_mode_a: assert property (data_wr |=> host_mode_o [*2])
    else $error("host write did not enter host-controlled operation");
  wdt_pulse_a: assert property (wdt_kick |=> kick_pulse_s)
    else $error("watchdog restart not a single pulse");
  boost_prio_a: assert property (boost_output_enable_o |=> !charge_enable_o)
    else $error("charging enabled while boost is set");
endmodule

//--- verification/host_bfm.sv
`timescale 1ns/1ns
module host_bfm (
  input  wire logic clk_sys_i,
  input  wire logic sda_line_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // ****
  // Serial host
  // ****
  // Bus free at time zero
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Four clocks a phase keeps each SCL phase above three
  task automatic half();
    repeat (4) @(posedge clk_sys_i);
  endtask
  // Data moves a clock after SCL falls; four clocks low, four high, 160 ns a bit
  task automatic bit_x(input logic b, output logic r);
    @(posedge clk_sys_i);
    sda_low_o <= ~b;
    repeat (3) @(posedge clk_sys_i);
    scl_o <= 1'b1;
    half();
    r = sda_line_i;
    scl_o <= 1'b0;
  endtask
  // Start or repeated start
  task automatic start();
    @(posedge clk_sys_i);
    sda_low_o <= 1'b0;
    half();
    scl_o <= 1'b1;
    half();
    sda_low_o <= 1'b1;
    half();
    scl_o <= 1'b0;
  endtask
  // Stop, then the bus stays free
  task automatic stop();
    @(posedge clk_sys_i);
    sda_low_o <= 1'b1;
    half();
    scl_o <= 1'b1;
    half();
    sda_low_o <= 1'b0;
    half();
  endtask
  // Byte MSB first, then ninth bit; send ff to read
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(a, k);
  endtask
endmodule

//--- verification/tb.sv
`timescale 1ns/1ns
module tb;
  import charger_regs_pkg::*;
  logic       clk_sys_i, arst_n_i, scl, sda_low, sda_oe, hiz, chg, boost, host, wdr, bc, rf;
  logic       sdo, wdx;
  src_type_t  src;
  logic [7:0] fault, status;
  logic [7:0] b [0:3];
  logic [3:0] vf;
  logic [2:0] cap, smin;
  logic [5:0] fast_charge_current;
  int         n_fail, checked, wd_n;
  wire        sda = ~(sda_low | (sda_oe & ~sdo));
  // ****
  // Harness
  // ****
  charger_i2c_register_bank charger_i2c_register_bank_inst (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda), .sda_o(sdo),
    .sda_oe_o(sda_oe), .fault_i(fault), .status_i(status), .src_type_i(src),
    .watchdog_expired_i(wdx), .input_high_impedance_enable_o(hiz),
    .input_voltage_floor_o(vf), .input_current_cap_o(cap), .boost_output_enable_o(boost),
    .charge_enable_o(chg), .min_system_voltage_o(smin), .fast_charge_current_o(fast_charge_current),
    .boost_cold_select_o(bc), .reduced_current_force_o(rf), .host_mode_o(host),
    .watchdog_restart_o(wdr));
  host_bfm host_bfm_inst (.clk_sys_i(clk_sys_i), .sda_line_i(sda), .scl_o(scl),
    .sda_low_o(sda_low));
  // 50 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  // Restart pulses are single cycles, so count them here
  always @(posedge clk_sys_i) if (wdr === 1'b1) wd_n <= wd_n + 1;
  task automatic check(input string nm, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic tx(input logic [7:0] d, input logic ak);
    logic [7:0] q;
    logic       k;
    host_bfm_inst.xfer(d, 1'b1, q, k);
    check("ack", {7'h0, k}, {7'h0, ak});
  endtask
  task automatic wr(input logic [7:0] r, input int n);
    host_bfm_inst.start();
    tx({SLAVE_ADDR, 1'b0}, 1'b0);
    tx(r, 1'b0);
    for (int i = 0; i < n; i++) tx(b[i], 1'b0);
    host_bfm_inst.stop();
  endtask
  // Last byte gets a not-acknowledge, as a host must end a read
  task automatic rd(input logic [7:0] r, input int n);
    logic k;
    host_bfm_inst.start();
    tx({SLAVE_ADDR, 1'b0}, 1'b0);
    tx(r, 1'b0);
    host_bfm_inst.start();
    tx({SLAVE_ADDR, 1'b1}, 1'b0);
    for (int i = 0; i < n; i++) host_bfm_inst.xfer(8'hff, i == n - 1, b[i], k);
    host_bfm_inst.stop();
  endtask
  task automatic rd3(input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2);
    rd(8'h00, 3);
    check("b0", b[0], e0);
    check("b1", b[1], e1);
    check("b2", b[2], e2);
  endtask
  task automatic t_reset();
    rd3(8'h5d, 8'h3b, 8'h20);
    check("chg", {7'h0, chg}, 8'h00);
  endtask
  task automatic t_write();
    b = '{8'hff, 8'h1c, 8'hfd, 8'h00};
    wr(8'h00, 3);
    check("host", {7'h0, host}, 8'h01);
    check("src", {hiz, vf, cap}, 8'hff);
    check("pwr", {2'h0, boost, chg, smin, 1'b0}, 8'h1c);
    check("cur", {fast_charge_current, bc, rf}, 8'hfd);
    rd3(8'hff, 8'h1c, 8'hfd);
  endtask
  // A write to the status byte must not spill into byte 00
  task automatic t_misc();
    status <= 8'ha5;
    b[0] = 8'h00;
    wr(8'h08, 1);
    rd(8'h08, 1);
    check("ro", b[0], 8'ha5);
    rd(8'h00, 1);
    check("ro0", b[0], 8'hff);
    host_bfm_inst.start();
    tx({SLAVE_ADDR, 1'b0}, 1'b0);
    tx(8'h0b, 1'b1);
    host_bfm_inst.stop();
  endtask
  // Two single-byte reads; the second shows only present faults
  task automatic t_fault();
    fault <= 8'h24;
    repeat (3) @(posedge clk_sys_i);
    fault <= 8'h00;
    rd(8'h09, 1);
    check("f1", b[0], 8'h24);
    rd(8'h09, 1);
    check("f2", b[0], 8'h00);
  endtask
  // One restart only, so the host spacing is kept trivially
  task automatic t_cmd();
    int c;
    c = wd_n;
    b[0] = 8'h5c;
    wr(8'h01, 1);
    check("wd", 8'(wd_n - c), 8'h01);
    rd(8'h01, 1);
    check("p1", b[0], 8'h1c);
    b[0] = 8'h80;
    wr(8'h01, 1);
    rd3(8'h5d, 8'h3b, 8'h20);
    check("keep", {7'h0, host}, 8'h01);
    // Watchdog expiry hands control back to default operation
    wdx <= 1'b1;
    @(posedge clk_sys_i);
    wdx <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    check("dflt", {7'h0, host}, 8'h00);
  endtask
  // Register reset reloads the current cap default of each source type
  task automatic t_src();
    logic [2:0] e [0:3];
    e = '{3'h2, 3'h5, 3'h6, 3'h4};
    for (int i = 0; i < 4; i++) begin
      src <= src_type_t'(i);
      b[0] = 8'h80;
      wr(8'h01, 1);
      rd(8'h00, 1);
      check("cap", b[0], {5'h0b, e[i]});
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Guard against a hung link
  initial begin
    #1500000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    arst_n_i = 1'b0;
    fault = 8'h00;
    status = 8'h00;
    src = SRC_DEDICATED;
    wdx = 1'b0;
    repeat (8) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    t_reset();
    t_write();
    t_misc();
    t_fault();
    t_cmd();
    t_src();
    tally_and_finish();
  end
endmodule
